// ===== rtl/tcc_cfg.svh
// Function
// - stream cache looked up by stream id; dropped by id, id span or all
// - context cache dropped by stream plus substream, by stream, or all
// - first-stage entries tagged va, address_space_tag, virtual_machine_tag, level; nested invalidation subsets
// - second-stage entries tagged ipa and virtual_machine_tag; dropped by both, virtual_machine_tag or all
// - lookup goes stream entry, then context, then translation buffers with derived tags
// - combined entry dropped by any invalidation that drops first-stage entries, and by second-stage virtual_machine_tag or all
// - merged entries may survive ipa invalidation; software follows with va invalidation
// - merged config and translation entries dropped unless proven not matching
// - stream invalidation also drops contexts and translations cached through it
// - stream world and security tag every translation inserted through that stream
// - stream stall-disable overrides the context stall flag on first-stage fault
// - 32-bit second stage with 64-bit first-stage context is illegal
// - nonsecure walk never yields secure output; walk config may force nonsecure
// - first-stage translation entries carry context address_space_tag and address_space_tag-set flag for matching
// - sign-extension failure of the input address gives a translation fault
// - with input addresses of 56 bits or fewer, top byte tagging is forced
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_SID_W      16
`define TCC_SSID_W     20
`define TCC_TAG_W      16
`define TCC_LVL_W      3
`define TCC_VA_W       64
`define TCC_PG_SH      12
`define TCC_PN_W       36
`define TCC_SPAN_W     5
`define TCC_VA_BITS    48
`define TCC_IN_BITS    64
`define TCC_TBI_LIMIT  56
`define TCC_ADDR_W     8
`define TCC_OFF_CTRL   8'h00
`define TCC_OFF_SID    8'h04
`define TCC_OFF_SSID   8'h08
`define TCC_OFF_ALO    8'h0c
`define TCC_OFF_AHI    8'h10
`define TCC_OFF_TAGS   8'h14
`define TCC_OFF_CMD    8'h18
`define TCC_OFF_STAT   8'h1c
`define TCC_OFF_MISS   8'h20
`define TCC_CTRL_RST   32'h0000_0000
`define TCC_CMD_LVL_LSB  4
`define TCC_CMD_SPAN_LSB 8
`define TCC_STAT_PEND_BIT 16
`endif

// ===== rtl/tcc_pkg.sv
package tcc_pkg;
`include "tcc_cfg.svh"

  typedef enum logic [3:0] {
    INV_NONE, INV_STE_SID, INV_STE_SPAN, INV_STE_ALL,
    INV_CD_SID_SSID, INV_CD_SID, INV_CD_ALL,
    INV_S1_VA, INV_S1_ADDRESS_SPACE_TAG, INV_S1_VIRTUAL_MACHINE_TAG, INV_S1_LVL,
    INV_S2_IPA, INV_S2_VIRTUAL_MACHINE_TAG, INV_S2_ALL
  } tcc_inv_op_type;

  typedef enum logic [1:0] {FILL_STE, FILL_CD, FILL_S1, FILL_S2} tcc_fill_kind_type;

  typedef struct packed {
    logic                     valid;
    logic [`TCC_SID_W-1:0]    sid;
    logic                     secure;
    logic [1:0]               world;
    logic                     s1_en;
    logic                     s2_en;
    logic                     s2_wide;
    logic                     stall_dis;
    logic [`TCC_TAG_W-1:0]    virtual_machine_tag;
  } tcc_ste_type;

  typedef struct packed {
    logic                     valid;
    logic [`TCC_SID_W-1:0]    sid;
    logic [`TCC_SSID_W-1:0]   ssid;
    logic [`TCC_TAG_W-1:0]    address_space_tag;
    logic                     address_space_set_flag;
    logic                     wide;
    logic                     stall;
    logic                     top_byte_tag_ignore;
    logic                     walk_sec;
  } tcc_cd_type;

  typedef struct packed {
    logic                              valid;
    logic [`TCC_SID_W-1:0]             sid;
    logic [`TCC_VA_W-`TCC_PG_SH-1:0]   vpn;
    logic [`TCC_TAG_W-1:0]             address_space_tag;
    logic                              address_space_set_flag;
    logic [`TCC_TAG_W-1:0]             virtual_machine_tag;
    logic [`TCC_LVL_W-1:0]             lvl;
    logic                              combined;
    logic                              ns;
    logic [`TCC_PN_W-1:0]              opn;
  } tcc_s1_type;

  typedef struct packed {
    logic                              valid;
    logic [`TCC_VA_W-`TCC_PG_SH-1:0]   ipn;
    logic [`TCC_TAG_W-1:0]             virtual_machine_tag;
    logic                              ns;
    logic [`TCC_PN_W-1:0]              opn;
  } tcc_s2_type;

  typedef struct packed {
    tcc_inv_op_type                    op;
    logic [`TCC_SID_W-1:0]             sid;
    logic [`TCC_SSID_W-1:0]            ssid;
    logic [`TCC_SPAN_W-1:0]            span;
    logic [`TCC_VA_W-`TCC_PG_SH-1:0]   vpn;
    logic [`TCC_TAG_W-1:0]             address_space_tag;
    logic [`TCC_TAG_W-1:0]             virtual_machine_tag;
    logic [`TCC_LVL_W-1:0]             lvl;
  } tcc_inv_type;

  typedef struct packed {
    logic [`TCC_SID_W-1:0]    sid;
    logic [`TCC_SSID_W-1:0]   ssid;
    logic                     ssv;
    logic                     secure;
    logic [`TCC_VA_W-1:0]     va;
  } tcc_req_type;

  typedef struct packed {
    logic                          hit;
    logic                          ste_miss;
    logic                          cd_miss;
    logic                          tlb_miss;
    logic                          fault;
    logic                          illegal;
    logic                          stall;
    logic                          ns;
    logic [`TCC_PN_W+`TCC_PG_SH-1:0] pa;
  } tcc_rsp_type;
endpackage

// ===== rtl/tcc_addr_check.sv
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_addr_check #(
  parameter int IN_BITS = `TCC_IN_BITS,
  parameter int VA_BITS = `TCC_VA_BITS
)(
  // address under test
  input  wire logic [63:0] va,
  input  wire logic        top_byte_tag_ignore,
  // result
  output logic             bad
);
  if (VA_BITS < 32 || VA_BITS > 56 || IN_BITS < VA_BITS || IN_BITS > 64)
  begin : g_chk
    $error("tcc_addr_check: unsupported address widths");
  end

  // truncated inputs cannot carry a checkable top byte
  localparam bit FORCE_TBI = (IN_BITS <= `TCC_TBI_LIMIT);

  logic tbi_eff;
  int   top;

  assign tbi_eff = top_byte_tag_ignore | FORCE_TBI;
  assign top     = tbi_eff ? ((IN_BITS < `TCC_TBI_LIMIT) ? IN_BITS : `TCC_TBI_LIMIT) : IN_BITS;

  // bits above the width never reached us, so they are not checked
  always_comb
  begin
    bad = 1'b0;
    for (int i = VA_BITS; i < 64; i++)
    begin
      if (i < top && va[i] != va[VA_BITS-1])
      begin
        bad = 1'b1;
      end
    end
  end
endmodule

// ===== rtl/tcc_top.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_top
  import tcc_pkg::*;
#(
  parameter int STE_N   = 4,
  parameter int CD_N    = 4,
  parameter int S1_N    = 8,
  parameter int S2_N    = 8,
  parameter int IN_BITS = `TCC_IN_BITS,
  parameter int VA_BITS = `TCC_VA_BITS
)(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`TCC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // client lookup
  input  wire logic                    req_valid,
  input  tcc_req_type                  req,
  output logic                         rsp_valid,
  output tcc_rsp_type                  rsp,
  // fills from the table walker
  input  wire logic                    fill_valid,
  input  tcc_fill_kind_type            fill_kind,
  input  tcc_ste_type                  fill_ste,
  input  tcc_cd_type                   fill_cd,
  input  tcc_s1_type                   fill_s1,
  input  tcc_s2_type                   fill_s2
);
  if (STE_N < 2 || CD_N < 2 || S1_N < 2 || S2_N < 2 || STE_N > 32 || CD_N > 32 ||
      S1_N > 32 || S2_N > 32 || (STE_N & (STE_N-1)) != 0 || (CD_N & (CD_N-1)) != 0 ||
      (S1_N & (S1_N-1)) != 0 || (S2_N & (S2_N-1)) != 0)
  begin : g_chk
    $error("tcc_top: entry counts must be powers of two from 2 to 32");
  end

  localparam int STE_W = $clog2(STE_N);
  localparam int CD_W  = $clog2(CD_N);
  localparam int S1_W  = $clog2(S1_N);
  localparam int S2_W  = $clog2(S2_N);
  localparam int VPN_W = `TCC_VA_W - `TCC_PG_SH;
  localparam int PA_W  = `TCC_PN_W + `TCC_PG_SH;

  // ************************************************************
  // match and invalidation decoding
  // ************************************************************
  function automatic int unsigned pick(input logic [31:0] v);
    int unsigned idx;
    idx = 0;
    for (int i = 31; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = i;
      end
    end
    return idx;
  endfunction

  function automatic logic ste_key(input tcc_ste_type e, input logic [`TCC_SID_W-1:0] sid,
                                   input logic sec);
    return e.valid && e.sid == sid && e.secure == sec;
  endfunction

  function automatic logic sid_op(input logic [`TCC_SID_W-1:0] s, input tcc_inv_type c);
    case (c.op)
      INV_STE_SID:  return s == c.sid;
      INV_STE_SPAN: return (s >> c.span) == (c.sid >> c.span);
      INV_STE_ALL:  return 1'b1;
      default:      return 1'b0;
    endcase
  endfunction

  function automatic logic inv_cd_f(input tcc_cd_type e, input tcc_inv_type c);
    case (c.op)
      INV_CD_SID_SSID: return e.sid == c.sid && e.ssid == c.ssid;
      INV_CD_SID:      return e.sid == c.sid;
      INV_CD_ALL:      return 1'b1;
      default:         return sid_op(e.sid, c);
    endcase
  endfunction

  function automatic logic inv_s1_f(input tcc_s1_type e, input tcc_inv_type c);
    case (c.op)
      INV_S1_VA:   return e.vpn == c.vpn && e.address_space_tag == c.address_space_tag && e.virtual_machine_tag == c.virtual_machine_tag && e.lvl == c.lvl;
      INV_S1_ADDRESS_SPACE_TAG: return e.address_space_tag == c.address_space_tag && e.virtual_machine_tag == c.virtual_machine_tag && e.lvl == c.lvl;
      INV_S1_VIRTUAL_MACHINE_TAG: return e.virtual_machine_tag == c.virtual_machine_tag && e.lvl == c.lvl;
      INV_S1_LVL:  return e.lvl == c.lvl;
      INV_S2_IPA:  return 1'b0;
      INV_S2_VIRTUAL_MACHINE_TAG: return e.combined && e.virtual_machine_tag == c.virtual_machine_tag;
      INV_S2_ALL:  return e.combined;
      INV_CD_SID_SSID, INV_CD_SID: return e.sid == c.sid;
      INV_CD_ALL:  return 1'b1;
      default:     return sid_op(e.sid, c);
    endcase
  endfunction

  function automatic logic inv_s2_f(input tcc_s2_type e, input tcc_inv_type c);
    case (c.op)
      INV_S2_IPA:  return e.ipn == c.vpn && e.virtual_machine_tag == c.virtual_machine_tag;
      INV_S2_VIRTUAL_MACHINE_TAG: return e.virtual_machine_tag == c.virtual_machine_tag;
      INV_S2_ALL:  return 1'b1;
      default:     return 1'b0;
    endcase
  endfunction

  // ************************************************************
  // storage
  // ************************************************************
  tcc_ste_type ste_mem [STE_N];
  tcc_cd_type  cd_mem  [CD_N];
  tcc_s1_type  s1_mem  [S1_N];
  tcc_s2_type  s2_mem  [S2_N];

  logic [STE_W-1:0] ste_ptr_reg;
  logic [CD_W-1:0]  cd_ptr_reg;
  logic [S1_W-1:0]  s1_ptr_reg;
  logic [S2_W-1:0]  s2_ptr_reg;

  tcc_inv_type      inv_reg;
  logic             inv_pend_reg;
  logic [31:0]      ctrl_reg;
  logic [15:0]      inv_cnt_reg;
  logic [31:0]      miss_cnt_reg;

  // ************************************************************
  // lookup chain: stream entry, context, translation
  // ************************************************************
  logic [STE_N-1:0] ste_hit_v;
  logic [STE_N-1:0] ste_fill_v;
  logic [CD_N-1:0]  cd_hit_v;
  logic [S1_N-1:0]  s1_hit_v;
  logic [S2_N-1:0]  s2_hit_v;
  logic [STE_N-1:0] ste_kill;
  logic [CD_N-1:0]  cd_kill;
  logic [S1_N-1:0]  s1_kill;
  logic [S2_N-1:0]  s2_kill;

  tcc_ste_type               ste_s;
  tcc_ste_type               ste_f;
  tcc_cd_type                cd_s;
  tcc_s1_type                s1_s;
  tcc_s2_type                s2_s;
  logic [`TCC_SSID_W-1:0]    req_ssid;
  logic [`TCC_LVL_W-1:0]     req_lvl;
  logic [VPN_W-1:0]          req_vpn;

  assign req_ssid = req.ssv ? req.ssid : '0;
  assign req_vpn  = req.va[`TCC_VA_W-1:`TCC_PG_SH];
  assign ste_s    = ste_mem[STE_W'(pick(32'(ste_hit_v)))];
  assign ste_f    = ste_mem[STE_W'(pick(32'(ste_fill_v)))];
  assign cd_s     = cd_mem[CD_W'(pick(32'(cd_hit_v)))];
  assign s1_s     = s1_mem[S1_W'(pick(32'(s1_hit_v)))];
  assign s2_s     = s2_mem[S2_W'(pick(32'(s2_hit_v)))];
  assign req_lvl  = {ste_s.secure, ste_s.world};

  for (genvar i = 0; i < STE_N; i++)
  begin : g_ste
    assign ste_hit_v[i]  = ste_key(ste_mem[i], req.sid, req.secure);
    assign ste_fill_v[i] = ste_key(ste_mem[i], fill_s1.sid, fill_s1.lvl[`TCC_LVL_W-1]);
    assign ste_kill[i]   = inv_pend_reg && sid_op(ste_mem[i].sid, inv_reg);
  end

  for (genvar i = 0; i < CD_N; i++)
  begin : g_cd
    assign cd_hit_v[i] = cd_mem[i].valid && cd_mem[i].sid == req.sid && cd_mem[i].ssid == req_ssid;
    assign cd_kill[i]  = inv_pend_reg && inv_cd_f(cd_mem[i], inv_reg);
  end

  // address_space_tag, virtual_machine_tag and level come from the cached configuration, never from the client
  for (genvar i = 0; i < S1_N; i++)
  begin : g_s1
    assign s1_hit_v[i] = s1_mem[i].valid && s1_mem[i].vpn == req_vpn && s1_mem[i].address_space_tag == cd_s.address_space_tag &&
                         s1_mem[i].address_space_set_flag == cd_s.address_space_set_flag && s1_mem[i].virtual_machine_tag == ste_s.virtual_machine_tag &&
                         s1_mem[i].lvl == req_lvl;
    assign s1_kill[i]  = inv_pend_reg && inv_s1_f(s1_mem[i], inv_reg);
  end

  for (genvar i = 0; i < S2_N; i++)
  begin : g_s2
    assign s2_hit_v[i] = s2_mem[i].valid && s2_mem[i].ipn == req_vpn && s2_mem[i].virtual_machine_tag == ste_s.virtual_machine_tag;
    assign s2_kill[i]  = inv_pend_reg && inv_s2_f(s2_mem[i], inv_reg);
  end

  logic ste_any;
  logic cd_any;
  logic addr_bad;

  assign ste_any = ctrl_reg[0] && |ste_hit_v;
  assign cd_any  = |cd_hit_v;

  tcc_addr_check #(
    .IN_BITS (IN_BITS),
    .VA_BITS (VA_BITS)
  ) u_addr_check (
    .va  (req.va),
    .top_byte_tag_ignore (cd_s.top_byte_tag_ignore),
    .bad (addr_bad)
  );

  tcc_rsp_type rsp_next;

  always_comb
  begin
    rsp_next          = '0;
    rsp_next.ste_miss = ~ste_any;
    rsp_next.stall    = cd_s.stall & ~ste_s.stall_dis;
    if (ste_any && ste_s.s1_en)
    begin
      rsp_next.cd_miss = ~cd_any;
      if (cd_any && ste_s.s2_en && !ste_s.s2_wide && cd_s.wide)
      begin
        rsp_next.illegal = 1'b1;
      end
      else if (cd_any && addr_bad)
      begin
        rsp_next.fault = 1'b1;
      end
      else if (cd_any)
      begin
        rsp_next.hit      = |s1_hit_v;
        rsp_next.tlb_miss = ~|s1_hit_v;
        rsp_next.ns       = s1_s.ns | cd_s.walk_sec | ~ste_s.secure;
        rsp_next.pa       = {s1_s.opn, req.va[`TCC_PG_SH-1:0]};
      end
    end
    else if (ste_any && ste_s.s2_en)
    begin
      rsp_next.hit      = |s2_hit_v;
      rsp_next.tlb_miss = ~|s2_hit_v;
      rsp_next.ns       = s2_s.ns | ~ste_s.secure;
      rsp_next.pa       = {s2_s.opn, req.va[`TCC_PG_SH-1:0]};
    end
    else if (ste_any)
    begin
      rsp_next.hit = 1'b1;
      rsp_next.ns  = ~ste_s.secure;
      rsp_next.pa  = req.va[PA_W-1:0];
    end
    if (!rsp_next.stall || !rsp_next.fault)
    begin
      rsp_next.stall = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_valid    <= 1'b0;
      rsp          <= '0;
      miss_cnt_reg <= '0;
    end
    else
    begin
      rsp_valid <= req_valid;
      rsp       <= req_valid ? rsp_next : '0;
      if (req_valid && (rsp_next.ste_miss || rsp_next.cd_miss || rsp_next.tlb_miss))
      begin
        miss_cnt_reg <= miss_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ************************************************************
  // fills; a fill hit by the pending invalidation is dropped
  // ************************************************************
  tcc_s1_type s1_new;
  logic       ste_we;
  logic       cd_we;
  logic       s1_we;
  logic       s2_we;

  always_comb
  begin
    s1_new          = fill_s1;
    s1_new.valid    = 1'b1;
    s1_new.lvl      = {ste_f.secure, ste_f.world};
    s1_new.virtual_machine_tag     = ste_f.virtual_machine_tag;
    s1_new.combined = ste_f.s2_en;
  end

  assign ste_we = fill_valid && fill_kind == FILL_STE && !(inv_pend_reg && sid_op(fill_ste.sid, inv_reg));
  assign cd_we  = fill_valid && fill_kind == FILL_CD && !(inv_pend_reg && inv_cd_f(fill_cd, inv_reg));
  assign s1_we  = fill_valid && fill_kind == FILL_S1 && |ste_fill_v &&
                  !(inv_pend_reg && inv_s1_f(s1_new, inv_reg));
  assign s2_we  = fill_valid && fill_kind == FILL_S2 && !(inv_pend_reg && inv_s2_f(fill_s2, inv_reg));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < STE_N; i++) ste_mem[i] <= '0;
      for (int i = 0; i < CD_N; i++)  cd_mem[i]  <= '0;
      for (int i = 0; i < S1_N; i++)  s1_mem[i]  <= '0;
      for (int i = 0; i < S2_N; i++)  s2_mem[i]  <= '0;
    end
    else
    begin
      for (int i = 0; i < STE_N; i++) if (ste_kill[i]) ste_mem[i].valid <= 1'b0;
      for (int i = 0; i < CD_N; i++)  if (cd_kill[i])  cd_mem[i].valid  <= 1'b0;
      for (int i = 0; i < S1_N; i++)  if (s1_kill[i])  s1_mem[i].valid  <= 1'b0;
      for (int i = 0; i < S2_N; i++)  if (s2_kill[i])  s2_mem[i].valid  <= 1'b0;
      if (ste_we) ste_mem[ste_ptr_reg] <= {1'b1, fill_ste[$bits(tcc_ste_type)-2:0]};
      if (cd_we)  cd_mem[cd_ptr_reg]   <= {1'b1, fill_cd[$bits(tcc_cd_type)-2:0]};
      if (s1_we)  s1_mem[s1_ptr_reg]   <= s1_new;
      if (s2_we)  s2_mem[s2_ptr_reg]   <= {1'b1, fill_s2[$bits(tcc_s2_type)-2:0]};
    end
  end

  // round robin victim choice; cheap, but a refill of a live tag leaves a stale twin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ste_ptr_reg <= '0;
      cd_ptr_reg  <= '0;
      s1_ptr_reg  <= '0;
      s2_ptr_reg  <= '0;
    end
    else
    begin
      ste_ptr_reg <= ste_ptr_reg + STE_W'(ste_we);
      cd_ptr_reg  <= cd_ptr_reg + CD_W'(cd_we);
      s1_ptr_reg  <= s1_ptr_reg + S1_W'(s1_we);
      s2_ptr_reg  <= s2_ptr_reg + S2_W'(s2_we);
    end
  end

  // ************************************************************
  // apb register file
  // ************************************************************
  logic [31:0] sid_reg;
  logic [31:0] ssid_reg;
  logic [31:0] alo_reg;
  logic [31:0] ahi_reg;
  logic [31:0] tags_reg;
  logic [31:0] cmd_reg;
  logic [31:0] rd_data;
  logic        apb_setup;
  logic        apb_wr;
  logic        addr_ok;
  logic        cmd_wr;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite && !pslverr;
  assign cmd_wr    = apb_wr && paddr == `TCC_OFF_CMD;
  assign addr_ok   = paddr[1:0] == 2'h0 && paddr <= `TCC_OFF_MISS;

  always_comb
  begin
    case (paddr)
      `TCC_OFF_CTRL: rd_data = ctrl_reg;
      `TCC_OFF_SID:  rd_data = sid_reg;
      `TCC_OFF_SSID: rd_data = ssid_reg;
      `TCC_OFF_ALO:  rd_data = alo_reg;
      `TCC_OFF_AHI:  rd_data = ahi_reg;
      `TCC_OFF_TAGS: rd_data = tags_reg;
      `TCC_OFF_CMD:  rd_data = cmd_reg;
      `TCC_OFF_STAT: rd_data = {15'h0000, inv_pend_reg, inv_cnt_reg};
      `TCC_OFF_MISS: rd_data = miss_cnt_reg;
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      prdata  <= (apb_setup && !pwrite) ? rd_data : '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= `TCC_CTRL_RST;
      sid_reg  <= '0;
      ssid_reg <= '0;
      alo_reg  <= '0;
      ahi_reg  <= '0;
      tags_reg <= '0;
      cmd_reg  <= '0;
    end
    else if (apb_wr)
    begin
      case (paddr)
        `TCC_OFF_CTRL: ctrl_reg <= {31'h0000_0000, pwdata[0]};
        `TCC_OFF_SID:  sid_reg  <= {16'h0000, pwdata[`TCC_SID_W-1:0]};
        `TCC_OFF_SSID: ssid_reg <= {12'h000, pwdata[`TCC_SSID_W-1:0]};
        `TCC_OFF_ALO:  alo_reg  <= {pwdata[31:`TCC_PG_SH], 12'h000};
        `TCC_OFF_AHI:  ahi_reg  <= pwdata;
        `TCC_OFF_TAGS: tags_reg <= pwdata;
        `TCC_OFF_CMD:  cmd_reg  <= {19'h00000, pwdata[12:0]};
        default:       ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // the command is latched on the write and applied to every array on the next edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      inv_pend_reg <= 1'b0;
      inv_reg      <= '0;
      inv_cnt_reg  <= '0;
    end
    else
    begin
      inv_pend_reg <= cmd_wr;
      if (inv_pend_reg)
      begin
        inv_cnt_reg <= inv_cnt_reg + 16'h0001;
      end
      if (cmd_wr)
      begin
        inv_reg.op   <= tcc_inv_op_type'(pwdata[3:0]);
        inv_reg.lvl  <= pwdata[`TCC_CMD_LVL_LSB +: `TCC_LVL_W];
        inv_reg.span <= pwdata[`TCC_CMD_SPAN_LSB +: `TCC_SPAN_W];
        inv_reg.sid  <= sid_reg[`TCC_SID_W-1:0];
        inv_reg.ssid <= ssid_reg[`TCC_SSID_W-1:0];
        inv_reg.vpn  <= {ahi_reg, alo_reg[31:`TCC_PG_SH]};
        inv_reg.address_space_tag <= tags_reg[15:0];
        inv_reg.virtual_machine_tag <= tags_reg[31:16];
      end
    end
  end
endmodule

// ===== tb/tcc_chk.sv
`timescale 1ns/1ps
module tcc_chk
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // lookup
  input wire logic        req_valid,
  input wire logic        rsp_valid,
  input tcc_rsp_type      rsp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ********
  // assertions
  // ********
  AST_RSP_NEXT: assert property (req_valid |=> rsp_valid) else $error("lookup unanswered");
  AST_RSP_ONLY: assert property (!req_valid |=> !rsp_valid && rsp == '0) else $error("stray answer");
  AST_ACCESS: assert property (psel && !penable |=> pready) else $error("no ready in access");
  AST_PULSE: assert property (pready |=> !pready && prdata == '0 && !pslverr) else $error("answer held");
  AST_ILLEGAL: assert property (rsp.illegal |-> !rsp.hit && !rsp.fault) else $error("illegal hit");
  AST_STALL: assert property (rsp.stall |-> rsp.fault) else $error("stall without fault");
  AST_FAULT: assert property (rsp.fault |-> !rsp.hit && !rsp.tlb_miss) else $error("fault hit");
  AST_MISS: assert property (rsp.ste_miss |-> !rsp.hit && !rsp.cd_miss) else $error("mixed miss");
endmodule

bind tcc_top tcc_chk tcc_chk_inst (.clk, .arst_n, .psel, .penable, .prdata, .pready, .pslverr,
  .req_valid, .rsp_valid, .rsp);

// ===== tb/tcc_client.sv
`timescale 1ns/1ps
module tcc_client
  import tcc_pkg::*;
(
  // lookup port
  input  wire logic   clk,
  output logic        req_valid,
  output tcc_req_type req,
  input  wire logic   rsp_valid,
  input  tcc_rsp_type rsp
);
  // ********
  // client device
  // ********
  initial
  begin
    req_valid = 1'b0;
    req       = '0;
  end
  // released lines carry inverted bits so a stale value never passes for a live one
  task automatic lookup(input tcc_req_type r, output tcc_rsp_type o, output logic got);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= r;
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= ~r;
    #1;
    got = rsp_valid;
    o   = rsp;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tb
  import tcc_pkg::*;
;
  localparam logic [15:0] SID = 16'h0005;
  logic              clk, arst_n, psel, penable, pwrite, pready, pslverr, req_valid, rsp_valid;
  logic              fill_valid, got, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd, lfsr;
  logic [63:0]       va;
  tcc_req_type       req;
  tcc_rsp_type       rsp, o;
  tcc_fill_kind_type fill_kind;
  tcc_ste_type       fill_ste;
  tcc_cd_type        fill_cd;
  tcc_s1_type        fill_s1;
  tcc_s2_type        fill_s2;
  int                n_errors, num_checks, cyc, ninv;
  tcc_top tcc_top_inst (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .req_valid, .req, .rsp_valid, .rsp, .fill_valid, .fill_kind, .fill_ste, .fill_cd, .fill_s1, .fill_s2);
  tcc_client tcc_client_inst (.clk, .req_valid, .req, .rsp_valid, .rsp);
  // ********
  // helpers
  // ********
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic ok);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("ERROR %0t result differs from model", $time);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fill(input tcc_fill_kind_type k);
    @(posedge clk);
    fill_valid <= 1'b1;
    fill_kind  <= k;
    @(posedge clk);
    fill_valid <= 1'b0;
  endtask
  task automatic inv(input logic [3:0] op);
    apb(1'b1, `TCC_OFF_CMD, {28'h0, op});
    ninv++;
    repeat (2) @(posedge clk);
  endtask
  // a stream refill would leave a duplicate tag, so the old one is dropped first
  task automatic cfg();
    inv(4'h3);
    fill(FILL_STE);
    fill(FILL_CD);
  endtask
  task automatic look(input logic [63:0] a);
    tcc_client_inst.lookup('{SID, 20'h0, 1'b0, 1'b0, a}, o, got);
    check(got);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (++cyc == 6000)
    begin
      n_errors++;
      finish_test();
    end
  // ********
  // scenarios
  // ********
  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, fill_valid} = '0;
    fill_kind = FILL_STE;
    fill_ste  = '{1'b1, SID, 1'b0, 2'b00, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0034};
    fill_cd   = '{1'b1, SID, 20'h0, 16'h0012, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    fill_s1   = '0;
    fill_s2   = '0;
    lfsr      = 32'hb575;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, `TCC_OFF_CTRL, 32'h0);
    check(rd === `TCC_CTRL_RST && err === 1'b0);
    apb(1'b0, 8'h24, 32'h0);
    check(err === 1'b1 && rd === 32'h0);
    look(64'h1000);
    check(o.ste_miss === 1'b1);
    apb(1'b1, `TCC_OFF_CTRL, 32'h1);
    apb(1'b1, `TCC_OFF_SID, {16'h0, SID});
    apb(1'b1, `TCC_OFF_TAGS, 32'h0034_0012);
    cfg();
    for (int op = 7; op <= 10; op++)
    begin
      lfsr = lfsr_next(lfsr);
      va   = {32'h0, lfsr};
      fill_s1 <= '{1'b1, SID, va[63:12], 16'h0012, 1'b0, 16'h0034, 3'h0, 1'b0, 1'b0, {4'h0, lfsr}};
      apb(1'b1, `TCC_OFF_ALO, va[31:0]);
      fill(FILL_S1);
      look(va);
      check(o.hit === 1'b1 && o.ns === 1'b1 && o.pa === {fill_s1.opn, va[11:0]});
      inv(op[3:0]);
      look(va);
      check(o.tlb_miss === 1'b1);
    end
    for (int sd = 0; sd < 2; sd++)
    begin
      fill_ste.stall_dis <= sd[0];
      cfg();
      look({16'h8000, va[47:0]});
      check(o.fault === 1'b1 && o.stall === !sd[0]);
    end
    fill_cd.top_byte_tag_ignore <= 1'b1;
    cfg();
    look({16'ha500, va[47:0]});
    check(o.fault === 1'b0 && o.tlb_miss === 1'b1);
    inv(4'h5);
    look(va);
    check(o.cd_miss === 1'b1);
    for (int op = 1; op <= 3; op++)
    begin
      fill(FILL_CD);
      inv(op[3:0]);
      look(va);
      check(o.ste_miss === 1'b1);
      fill(FILL_STE);
      look(va);
      check(o.cd_miss === 1'b1);
    end
    fill_ste.s2_en <= 1'b1;
    fill_cd.wide   <= 1'b1;
    cfg();
    look(va);
    check(o.illegal === 1'b1);
    fill_cd.wide <= 1'b0;
    cfg();
    fill(FILL_S1);
    inv(4'hb);
    look(va);
    check(o.hit === 1'b1);
    inv(4'hc);
    look(va);
    check(o.tlb_miss === 1'b1);
    fill_ste.s1_en <= 1'b0;
    fill_s2 <= '{1'b1, va[63:12], 16'h0034, 1'b0, 36'h000000abc};
    cfg();
    fill(FILL_S2);
    look(va);
    check(o.hit === 1'b1 && o.pa === {36'h000000abc, va[11:0]});
    inv(4'hb);
    look(va);
    check(o.tlb_miss === 1'b1);
    apb(1'b0, `TCC_OFF_STAT, 32'h0);
    check(rd[15:0] === ninv[15:0] && rd[16] === 1'b0);
    finish_test();
  end
endmodule
